//--- dlprc_pkg.sv
package dlprc_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int PD_EXIT_NS = 4000;
  localparam int PD_EXIT_CYC = (PD_EXIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int NUM_CH = 4;
  localparam int DATA_W = 16;
  localparam logic [2:0] CMD_WR_IN = 3'h0;
  localparam logic [2:0] CMD_UPD = 3'h1;
  localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
  localparam logic [2:0] CMD_WR_UPD = 3'h3;
  localparam logic [2:0] CMD_PWR = 3'h4;
  localparam logic [2:0] CMD_RESET = 3'h5;
  localparam logic [2:0] CMD_MASK = 3'h6;
  localparam logic [2:0] CMD_REF = 3'h7;
  localparam logic [2:0] ADDR_ALL = 3'h7;
  localparam int MODE_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam int RST_FULL_BIT = 0;
  localparam int REF_ON_BIT = 0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_1K = 2'h1;
  localparam logic [1:0] PWR_100K = 2'h2;
  localparam logic [1:0] PWR_HIZ = 2'h3;
  localparam logic [0:0] REF_RST = 1'h0;
  localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_MID = 16'h8000;
  localparam int CNT_W = 6;

  typedef struct packed {
    logic [2:0] cmd;
    logic [2:0] addr;
    logic [DATA_W-1:0] data;
  } dlprc_cmd_s;
endpackage

//--- dlprc_ctrl.sv
`timescale 1ns/1ps
module dlprc_ctrl
  import dlprc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic POR_ACTIVE_I,
  input wire logic POR_MIDSCALE_I,
  input wire logic HAS_LOAD_PIN_I,
  input wire logic CMD_VALID_I,
  input wire dlprc_cmd_s CMD_I,
  input wire logic LOAD_OUTPUT_STROBE_N_I,
  input wire logic CLEAR_INPUT_N_I,
  output logic [NUM_CH*DATA_W-1:0] DAC_CODE_O,
  output logic [NUM_CH*2-1:0] PWR_MODE_O,
  output logic [NUM_CH-1:0] OUT_VALID_O,
  output logic REF_ON_O,
  output logic [3:0] LOAD_MASK_O,
  output logic SHIFT_CLEAR_O
);
  logic [DATA_W-1:0] in_reg [NUM_CH];
  logic [DATA_W-1:0] in_next [NUM_CH];
  logic [DATA_W-1:0] out_reg [NUM_CH];
  logic [DATA_W-1:0] out_next [NUM_CH];
  logic [NUM_CH-1:0] dirty_reg, dirty_next;
  logic [3:0] mask_reg, mask_next;
  logic [1:0] pwr_reg [NUM_CH];
  logic [1:0] pwr_next [NUM_CH];
  logic [CNT_W-1:0] settle_reg [NUM_CH];
  logic [CNT_W-1:0] settle_next [NUM_CH];
  logic ref_reg, ref_next;
  logic strobe_d_reg, strobe_d_next;
  logic shclr_reg, shclr_next;
  logic [DATA_W-1:0] por_code_reg, por_code_next;

  function automatic logic [1:0] mode_field(input dlprc_cmd_s c);
    return c.data[MODE_LSB+:2];
  endfunction

  function automatic logic [NUM_CH-1:0] addr_sel(input logic [2:0] a);
    logic [NUM_CH-1:0] s;
    s = '0;
    if (a == ADDR_ALL) begin
      s = '1;
    end else if (a < 3'(NUM_CH)) begin
      s[a[1:0]] = 1'b1;
    end
    return s;
  endfunction

  always_comb begin
    logic [NUM_CH-1:0] sel, wr, upd, pin_ld;
    logic fall;
    // Command only acts while CMD_VALID_I is high and POR_ACTIVE_I is low
    sel = addr_sel(CMD_I.addr);
    wr = '0;
    upd = '0;
    pin_ld = '0;
    fall = strobe_d_reg & ~LOAD_OUTPUT_STROBE_N_I & ~POR_ACTIVE_I;
    // Clear pin has no action in this block
    if (POR_ACTIVE_I) begin
      strobe_d_next = 1'b1;
    end else begin
      strobe_d_next = LOAD_OUTPUT_STROBE_N_I;
    end
    mask_next = mask_reg;
    ref_next = ref_reg;
    shclr_next = 1'b0;
    dirty_next = dirty_reg;
    por_code_next = por_code_reg;
    if (POR_ACTIVE_I) begin
      if (POR_MIDSCALE_I) begin
        por_code_next = CODE_MID;
      end else begin
        por_code_next = CODE_ZERO;
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      in_next[i] = in_reg[i];
      out_next[i] = out_reg[i];
      pwr_next[i] = pwr_reg[i];
      // Exit settle count runs down to zero
      if (settle_reg[i] != '0) begin
        settle_next[i] = settle_reg[i] - 1'b1;
      end else begin
        settle_next[i] = settle_reg[i];
      end
    end
    if (CMD_VALID_I && !POR_ACTIVE_I) begin
      unique case (CMD_I.cmd)
        CMD_WR_IN: wr = sel;
        CMD_UPD: upd = sel;
        CMD_WR_UPD_ALL: begin
          wr = sel;
          upd = '1;
        end
        CMD_WR_UPD: begin
          wr = sel;
          upd = sel;
        end
        CMD_PWR: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (CMD_I.data[SEL_LSB+i]) begin
              if (pwr_reg[i] != PWR_NORMAL && mode_field(CMD_I) == PWR_NORMAL) begin
                settle_next[i] = CNT_W'(PD_EXIT_CYC);
              end
              pwr_next[i] = mode_field(CMD_I);
            end
          end
        end
        CMD_RESET: begin
          shclr_next = 1'b1;
          dirty_next = '0;
          for (int i = 0; i < NUM_CH; i++) begin
            out_next[i] = CODE_ZERO;
          end
          if (CMD_I.data[RST_FULL_BIT]) begin
            mask_next = MASK_RST;
            ref_next = REF_RST;
            for (int i = 0; i < NUM_CH; i++) begin
              pwr_next[i] = PWR_NORMAL;
              settle_next[i] = '0;
            end
          end
        end
        CMD_MASK: mask_next = CMD_I.data[3:0];
        CMD_REF: ref_next = CMD_I.data[REF_ON_BIT];
      endcase
    end
    if (HAS_LOAD_PIN_I) begin
      // Pin low while writing gives synchronous load
      if (!LOAD_OUTPUT_STROBE_N_I && !POR_ACTIVE_I) begin
        pin_ld = wr;
      end
    end else begin
      pin_ld = '0;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (wr[i]) begin
        in_next[i] = CMD_I.data;
        dirty_next[i] = 1'b1;
      end
      if (wr[i] && (mask_reg[i] || pin_ld[i] || upd[i])) begin
        out_next[i] = CMD_I.data;
        dirty_next[i] = 1'b0;
      end else if ((upd[i] || (HAS_LOAD_PIN_I && fall)) && dirty_reg[i]) begin
        out_next[i] = in_reg[i];
        dirty_next[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      mask_reg <= MASK_RST;
      ref_reg <= REF_RST;
      strobe_d_reg <= 1'b1;
      shclr_reg <= 1'b0;
      dirty_reg <= '0;
      por_code_reg <= CODE_ZERO;
      for (int i = 0; i < NUM_CH; i++) begin
        in_reg[i] <= CODE_ZERO;
        out_reg[i] <= CODE_ZERO;
        pwr_reg[i] <= PWR_NORMAL;
        settle_reg[i] <= '0;
      end
    end else if (POR_ACTIVE_I) begin
      mask_reg <= MASK_RST;
      ref_reg <= REF_RST;
      strobe_d_reg <= 1'b1;
      shclr_reg <= 1'b0;
      dirty_reg <= '0;
      por_code_reg <= por_code_next;
      for (int i = 0; i < NUM_CH; i++) begin
        in_reg[i] <= por_code_next;
        out_reg[i] <= por_code_next;
        pwr_reg[i] <= PWR_NORMAL;
        settle_reg[i] <= '0;
      end
    end else begin
      mask_reg <= mask_next;
      ref_reg <= ref_next;
      strobe_d_reg <= strobe_d_next;
      shclr_reg <= shclr_next;
      dirty_reg <= dirty_next;
      por_code_reg <= por_code_next;
      for (int i = 0; i < NUM_CH; i++) begin
        in_reg[i] <= in_next[i];
        out_reg[i] <= out_next[i];
        pwr_reg[i] <= pwr_next[i];
        settle_reg[i] <= settle_next[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      DAC_CODE_O[i*DATA_W+:DATA_W] = out_reg[i];
      PWR_MODE_O[i*2+:2] = pwr_reg[i];
      OUT_VALID_O[i] = (pwr_reg[i] == PWR_NORMAL) && (settle_reg[i] == '0);
    end
  end

  assign REF_ON_O = ref_reg;
  assign LOAD_MASK_O = mask_reg;
  assign SHIFT_CLEAR_O = shclr_reg;
endmodule

//--- dlprc_ctrl_checker.sv
`timescale 1ns/1ps
module dlprc_ctrl_checker
  import dlprc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic POR_ACTIVE_I,
  input wire logic POR_MIDSCALE_I,
  input wire logic HAS_LOAD_PIN_I,
  input wire logic CMD_VALID_I,
  input wire dlprc_cmd_s CMD_I,
  input wire logic LOAD_OUTPUT_STROBE_N_I,
  input wire logic [NUM_CH*DATA_W-1:0] DAC_CODE_O,
  input wire logic [NUM_CH*2-1:0] PWR_MODE_O,
  input wire logic [NUM_CH-1:0] OUT_VALID_O,
  input wire logic REF_ON_O,
  input wire logic [3:0] LOAD_MASK_O,
  input wire logic SHIFT_CLEAR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  logic t;
  logic a0;
  logic [2:0] c;
  logic [15:0] d;
  assign t = CMD_VALID_I && !POR_ACTIVE_I;
  assign a0 = CMD_I.addr == 3'h0;
  assign c = CMD_I.cmd;
  assign d = CMD_I.data;
  AST_MASK: assert property (t && c == CMD_MASK |=> LOAD_MASK_O == $past(d[3:0]))
    else $error("mask");
  AST_REF: assert property (t && c == CMD_REF |=> REF_ON_O == $past(d[0]))
    else $error("ref");
  AST_SRST: assert property (t && c == CMD_RESET |=> SHIFT_CLEAR_O && DAC_CODE_O == '0)
    else $error("reset");
  AST_FULL: assert property (t && c == CMD_RESET && d[0] |=> !REF_ON_O && PWR_MODE_O == '0
    && LOAD_MASK_O == MASK_RST) else $error("full reset");
  AST_PWR: assert property (t && c == CMD_PWR && d[0] |=> PWR_MODE_O[1:0] == $past(d[5:4]))
    else $error("mode");
  AST_KEEP: assert property (t && c == CMD_PWR && !d[0] |=> $stable(PWR_MODE_O[1:0]))
    else $error("mode kept");
  AST_PDKEEP: assert property (t && c == CMD_PWR && LOAD_OUTPUT_STROBE_N_I |=> $stable(DAC_CODE_O))
    else $error("code kept");
  AST_POR: assert property (POR_ACTIVE_I |=>
    DAC_CODE_O[15:0] == ($past(POR_MIDSCALE_I) ? CODE_MID : CODE_ZERO)) else $error("por");
  AST_SYNC: assert property (t && c == CMD_WR_IN && a0 && LOAD_MASK_O[0] |=>
    DAC_CODE_O[15:0] == $past(d)) else $error("sync");
  AST_ASYNC: assert property (t && c == CMD_WR_IN && a0 && !LOAD_MASK_O[0] && HAS_LOAD_PIN_I
    && LOAD_OUTPUT_STROBE_N_I |=> $stable(DAC_CODE_O[15:0])) else $error("async");
  AST_WU: assert property (t && c == CMD_WR_UPD && a0 |=> DAC_CODE_O[15:0] == $past(d))
    else $error("write update");
  AST_VALID: assert property (t && c == CMD_PWR && d[0] && (d[5:4] != 2'h0 || PWR_MODE_O[1:0] != 2'h0)
    |=> !OUT_VALID_O[0]) else $error("output valid");
  cover property (t && c == CMD_MASK);
  cover property (t && c == CMD_PWR);
  cover property (t && c == CMD_RESET && d[0]);
endmodule

//--- dlprc_host.sv
`timescale 1ns/1ps
module dlprc_host
  import dlprc_pkg::*;
(
  input wire logic clk_i,
  output logic valid_o,
  output dlprc_cmd_s cmd_o
);
  initial begin
    valid_o = 1'b0;
    cmd_o = '0;
  end
  task automatic send(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d);
    @(negedge clk_i);
    valid_o <= 1'b1;
    cmd_o <= '{c, a, d};
    @(negedge clk_i);
    valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
  endtask
endmodule

//--- dlprc_ctrl_tb_top.sv
`timescale 1ns/1ps
module dlprc_ctrl_tb_top;
  import dlprc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, por = 1'b1, ld_n = 1'b1, clr_n = 1'b1;
  logic vld, ref_on, rdy = 1'b0, sp = 1'b1, r = 1'b0, dt = 1'b0, mid = 1'b1;
  dlprc_cmd_s cmd;
  logic [63:0] dac;
  logic [7:0] pwr, p = '0;
  logic [3:0] msk, m = '0;
  logic [28:0] q[$];
  logic [28:0] e;
  logic [15:0] in0, o0;
  logic [31:0] x = 32'h00013ac2;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  dlprc_host i_dlprc_host (.clk_i(clk), .valid_o(vld), .cmd_o(cmd));
  dlprc_ctrl i_dlprc_ctrl (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .POR_ACTIVE_I(por),
    .POR_MIDSCALE_I(mid), .HAS_LOAD_PIN_I(1'b1), .CMD_VALID_I(vld), .CMD_I(cmd),
    .LOAD_OUTPUT_STROBE_N_I(ld_n), .CLEAR_INPUT_N_I(clr_n), .DAC_CODE_O(dac),
    .PWR_MODE_O(pwr), .OUT_VALID_O(), .REF_ON_O(ref_on), .LOAD_MASK_O(msk), .SHIFT_CLEAR_O());
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmdx(input logic [2:0] c, input logic [31:0] d);
    logic [31:0] w;
    w = rnd();
    clr_n <= w[3];
    case (c)
      CMD_WR_IN: begin
        in0 = d[15:0];
        dt = !m[0];
        if (m[0]) o0 = d[15:0];
      end
      CMD_UPD: begin
        if (dt) o0 = in0;
        dt = 1'b0;
      end
      CMD_PWR: for (int i = 0; i < 4; i++) if (d[i]) p[2*i+:2] = d[5:4];
      CMD_RESET: begin
        o0 = CODE_ZERO;
        dt = 1'b0;
        if (d[0]) {m, r, p} = '0;
      end
      CMD_MASK: m = d[3:0];
      CMD_REF: r = d[0];
      default: begin
        in0 = d[15:0];
        o0 = d[15:0];
        dt = 1'b0;
      end
    endcase
    q.push_back({m, r, p, o0});
    i_dlprc_host.send(c, c[2] ? w[2:0] : 3'h0, d[15:0]);
  endtask
  task automatic strobe();
    if (dt) o0 = in0;
    dt = 1'b0;
    q.push_back({m, r, p, o0});
    @(negedge clk);
    ld_n <= 1'b0;
    repeat (2) @(negedge clk);
    ld_n <= 1'b1;
  endtask
  always @(posedge clk) begin
    rdy <= vld | (sp & ~ld_n);
    sp <= ld_n;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      results();
    end
  end
  always @(negedge clk) begin
    if (rdy && q.size() > 0) begin
      e = q.pop_front();
      cmp_count++;
      if ({msk, ref_on, pwr, dac[15:0]} !== e) begin
        $display("mismatch state exp %h got %h", e, {msk, ref_on, pwr, dac[15:0]});
        fail_count++;
      end
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    ld_n <= 1'b0;
    repeat (2) @(negedge clk);
    ld_n <= 1'b1;
    @(negedge clk);
    por <= 1'b0;
    in0 = CODE_MID;
    o0 = CODE_MID;
    for (int k = 0; k < 48; k++) cmdx(k[2:0], rnd());
    @(negedge clk);
    por <= 1'b1;
    mid <= 1'b0;
    repeat (2) @(negedge clk);
    por <= 1'b0;
    {m, r, p, dt} = '0;
    in0 = CODE_ZERO;
    o0 = CODE_ZERO;
    cmdx(CMD_MASK, '0);
    cmdx(CMD_WR_IN, rnd());
    strobe();
    strobe();
    results();
  end
endmodule
bind dlprc_ctrl dlprc_ctrl_checker i_dlprc_ctrl_checker (.*);
